/* File: hdl/lcd_port_pkg.sv */
// Shared constants and carrier types for the LCD controller write port
package lcd_port_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register bus layout, byte addresses of 32-bit words
  localparam int unsigned AXI_ADDR_W = 8;
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CONTROL = 8'h04;
  localparam logic [7:0] REG_DISPLAY = 8'h08;
  localparam logic [7:0] REG_LEVELS = 8'h0C;
  localparam logic [7:0] REG_ICONS = 8'h10;
  localparam logic [7:0] REG_BYTES = 8'h14;
  localparam int unsigned CTRL_SOFT_INIT_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // Internal write path: RAM map locations held inside this block
  localparam logic [6:0] ADDR_ICON_FIRST = 7'h20;
  localparam logic [6:0] ADDR_ICON_LAST = 7'h23;
  localparam logic [6:0] ADDR_DRIVE_STEP = 7'h28;
  localparam logic [6:0] ADDR_LED = 7'h2A;
  localparam logic [6:0] ADDR_HOME = 7'h30;
  localparam logic [6:0] ADDR_RESET = 7'h00;

  // Command codes, upper nibble of a command byte
  localparam logic [3:0] CMD_HOME = 4'h1;
  localparam logic [3:0] CMD_DISPLAY = 4'h3;
  localparam logic [3:0] CMD_POWER_SAVE = 4'h4;
  localparam logic [3:0] CMD_POWER_CTRL = 4'h5;
  localparam logic [3:0] CMD_SYSTEM = 4'h6;
  localparam int unsigned CMD_ADDR_SET_BIT = 7;

  // Drive level: reference spans this many steps of the subtracted unit
  localparam logic [6:0] DRIVE_FULL_SCALE = 7'h5F;
  localparam logic [4:0] DRIVE_STEP_RESET = 5'h00;

  ////////////////////////////////////////////////////////////////////////
  // Carrier types
  typedef enum logic {PH_HIGH, PH_LOW} nibble_phase_t;

  typedef struct packed {
    logic ps;
    logic family;
    logic width;
    logic cs_n;
    logic a0;
    logic strobe;
    logic [7:0] data;
    logic init_n;
  } host_pins_t;

  // Idle pin levels used while the synchroniser is in reset
  localparam host_pins_t PINS_IDLE = '{ps: 1'b0, family: 1'b0, width: 1'b0, cs_n: 1'b1,
                                      a0: 1'b0, strobe: 1'b0, data: 8'h00, init_n: 1'b1};

  typedef struct packed {
    logic display_on;
    logic double_height;
    logic blink_on;
    logic cursor_on;
    logic osc_on;
    logic power_save;
    logic power_on;
    logic two_lines;
    logic flip_h;
    logic flip_v;
    logic cgram_used;
    logic standby;
    logic dynamic_en;
    logic [4:0] drive_step;
    logic [6:0] drive_ratio;
    logic [19:0] icons;
    logic [4:0] led;
  } panel_ctrl_t;

  typedef struct packed {
    logic valid;
    logic [6:0] addr;
    logic [7:0] data;
  } ram_write_t;

endpackage

/* File: hdl/lcd_write_port.sv */
// Host write port of a character LCD controller with AXI4-Lite status access
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps

// Notes on behaviour
// - select pin high parallel, low serial
// - family pin high enable, low write strobe
// - width pin high eight bits, low four
// - four-bit mode sends each byte as two nibbles, high first
// - serial path: 8-bit shifter, 3-bit counter
// - chip select high clears shifter, counter
// - sample serial data on rising clock, MSB first
// - eighth rising clock hands byte onward
// - qualifier sampled on eighth serial clock
// - qualifier high writes RAM, low commands
// - deselected ignores inputs; reset still acts
// - five-bit step picks one of 32 levels
// - standby shows static icons only
// - device reset clears all control state
module lcd_write_port
  import lcd_port_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [AXI_ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [AXI_ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Host pins, asynchronous
  input wire logic parallel_serial_select,
  input wire logic bus_family_select,
  input wire logic bus_width_select,
  input wire logic chip_select_n,
  input wire logic data_command_select,
  input wire logic write_strobe,
  input wire logic [7:0] data_bus_in,
  input wire logic device_init_n,
  // Panel control and RAM write path
  output panel_ctrl_t panel,
  output ram_write_t ram_wr
);

  typedef struct packed {
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic strobe_prev;
    logic scl_prev;
    logic [7:0] cap_data;
    logic cap_a0;
    logic [7:0] shift;
    logic [2:0] cnt;
    nibble_phase_t phase;
    logic [3:0] hi_nibble;
    logic [6:0] addr_cnt;
    logic [15:0] bytes;
    panel_ctrl_t ctl;
    ram_write_t ram;
  } port_state_t;

  port_state_t st_reg;
  port_state_t st_next;
  host_pins_t pins;
  logic fire;
  logic [7:0] fire_byte;
  logic fire_a0;
  logic init_req;
  logic par_edge;
  logic scl_rise;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser; all pins share one delay so their timing stays aligned
  pin_sync #(
    .W($bits(host_pins_t)),
    .IDLE(PINS_IDLE)
  ) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pins_in({parallel_serial_select, bus_family_select, bus_width_select, chip_select_n,
              data_command_select, write_strobe, data_bus_in, device_init_n}),
    .pins_out(pins)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic: bus slave, byte assembly, command decode
  always_comb begin
    logic cs_on;
    logic strobe_act;
    logic soft_init;
    cs_on = !pins.cs_n;
    soft_init = 1'b0;
    strobe_act = 1'b0;
    st_next = st_reg;
    st_next.ram.valid = 1'b0;
    fire = 1'b0;
    fire_byte = 8'h00;
    fire_a0 = 1'b0;

    // Write channel: address and data taken in either order
    if (awvalid && !st_reg.aw_held) begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = awaddr;
    end
    if (wvalid && !st_reg.w_held) begin
      st_next.w_held = 1'b1;
      st_next.w_data = wdata;
      st_next.w_strb = wstrb;
    end
    if (st_reg.bvalid && bready) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid) begin
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      case (st_reg.aw_addr[7:2])
        REG_CONTROL[7:2]: soft_init = st_reg.w_strb[0] && st_reg.w_data[CTRL_SOFT_INIT_BIT];
        REG_STATUS[7:2], REG_DISPLAY[7:2], REG_LEVELS[7:2], REG_ICONS[7:2], REG_BYTES[7:2]: ;
        default: st_next.bresp = RESP_SLVERR;
      endcase
    end

    // Read channel: one read in flight, answered the next cycle
    if (st_reg.rvalid && rready) begin
      st_next.rvalid = 1'b0;
    end
    if (arvalid && !st_reg.rvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = RESP_OKAY;
      case (araddr[7:2])
        REG_STATUS[7:2]: st_next.rdata = {9'h0, st_reg.addr_cnt, 5'h0, st_reg.cnt,
                                          1'b0, st_reg.phase == PH_LOW, st_reg.ctl.dynamic_en,
                                          st_reg.ctl.standby, pins.cs_n, pins.width, pins.family, pins.ps};
        REG_DISPLAY[7:2]: st_next.rdata = {21'h0, st_reg.ctl.cgram_used, st_reg.ctl.flip_v,
                                           st_reg.ctl.flip_h, st_reg.ctl.two_lines, st_reg.ctl.power_on,
                                           st_reg.ctl.power_save, st_reg.ctl.osc_on, st_reg.ctl.cursor_on,
                                           st_reg.ctl.blink_on, st_reg.ctl.double_height,
                                           st_reg.ctl.display_on};
        REG_LEVELS[7:2]: st_next.rdata = {15'h0, st_reg.ctl.led, st_reg.ctl.drive_ratio, st_reg.ctl.drive_step};
        REG_ICONS[7:2]: st_next.rdata = {12'h0, st_reg.ctl.icons};
        REG_BYTES[7:2]: st_next.rdata = {16'h0, st_reg.bytes};
        REG_CONTROL[7:2]: st_next.rdata = 32'h0;
        default: begin
          st_next.rdata = 32'h0;
          st_next.rresp = RESP_SLVERR;
        end
      endcase
    end

    // Strobe polarity by bus family; width and family are don't-care in serial
    strobe_act = pins.family ? pins.strobe : !pins.strobe;
    par_edge = pins.ps && cs_on && st_reg.strobe_prev && !strobe_act;
    scl_rise = !pins.ps && cs_on && pins.data[6] && !st_reg.scl_prev;
    st_next.strobe_prev = pins.ps && cs_on && strobe_act;
    st_next.scl_prev = pins.data[6]; // Follows the pin while deselected: selecting with clock high is no edge
    // Data and qualifier are held from the last cycle the strobe was active
    if (strobe_act) begin
      st_next.cap_data = pins.data;
      st_next.cap_a0 = pins.a0;
    end

    // Serial assembly; deselect holds shifter, counter and nibble phase clear
    if (!cs_on) begin
      st_next.shift = 8'h00;
      st_next.cnt = 3'h0;
      st_next.phase = PH_HIGH;
    end else if (scl_rise) begin
      st_next.shift = {st_reg.shift[6:0], pins.data[7]};
      st_next.cnt = st_reg.cnt + 3'h1;
      if (st_reg.cnt == 3'h7) begin
        fire = 1'b1;
        fire_byte = {st_reg.shift[6:0], pins.data[7]};
        fire_a0 = pins.a0;
      end
    end

    // Parallel assembly, one byte per strobe or two nibbles on the upper lines
    if (par_edge) begin
      if (pins.width) begin
        fire = 1'b1;
        fire_byte = st_reg.cap_data;
        fire_a0 = st_reg.cap_a0;
      end else if (st_reg.phase == PH_HIGH) begin
        st_next.hi_nibble = st_reg.cap_data[7:4];
        st_next.phase = PH_LOW;
      end else begin
        fire = 1'b1;
        fire_byte = {st_reg.hi_nibble, st_reg.cap_data[7:4]};
        fire_a0 = st_reg.cap_a0;
        st_next.phase = PH_HIGH;
      end
    end

    // Write path; the port keeps no queue, so bytes must not come faster than it takes them
    init_req = !pins.init_n || soft_init;
    if (init_req) begin
      st_next.ctl = '0;
      st_next.ctl.drive_step = DRIVE_STEP_RESET;
      st_next.addr_cnt = ADDR_RESET;
    end else if (fire) begin
      st_next.bytes = st_reg.bytes + 16'h1;
      if (fire_a0) begin
        st_next.ram.valid = 1'b1;
        st_next.ram.addr = st_reg.addr_cnt;
        st_next.ram.data = fire_byte;
        st_next.addr_cnt = st_reg.addr_cnt + 7'h01;
        if (st_reg.addr_cnt >= ADDR_ICON_FIRST && st_reg.addr_cnt <= ADDR_ICON_LAST) begin
          case (st_reg.addr_cnt[1:0])
            2'h0: st_next.ctl.icons[4:0] = fire_byte[4:0];
            2'h1: st_next.ctl.icons[9:5] = fire_byte[4:0];
            2'h2: st_next.ctl.icons[14:10] = fire_byte[4:0];
            default: st_next.ctl.icons[19:15] = fire_byte[4:0];
          endcase
        end
        if (st_reg.addr_cnt == ADDR_DRIVE_STEP) begin
          st_next.ctl.drive_step = fire_byte[4:0];
        end
        if (st_reg.addr_cnt == ADDR_LED) begin
          st_next.ctl.led = fire_byte[4:0];
        end
      end else if (fire_byte[CMD_ADDR_SET_BIT]) begin
        st_next.addr_cnt = fire_byte[6:0];
      end else begin
        case (fire_byte[7:4])
          CMD_HOME: st_next.addr_cnt = ADDR_HOME;
          CMD_DISPLAY: begin
            st_next.ctl.cursor_on = fire_byte[3];
            st_next.ctl.blink_on = fire_byte[2];
            st_next.ctl.double_height = fire_byte[1];
            st_next.ctl.display_on = fire_byte[0];
          end
          CMD_POWER_SAVE: begin
            st_next.ctl.osc_on = fire_byte[1];
            st_next.ctl.power_save = fire_byte[0];
          end
          CMD_POWER_CTRL: st_next.ctl.power_on = fire_byte[0];
          CMD_SYSTEM: begin
            st_next.ctl.two_lines = fire_byte[3];
            st_next.ctl.flip_h = fire_byte[2];
            st_next.ctl.flip_v = fire_byte[1];
            st_next.ctl.cgram_used = fire_byte[0];
          end
          default: ;
        endcase
      end
    end

    // Derived panel state kept in flops so the outputs stay glitch free
    st_next.ctl.drive_ratio = DRIVE_FULL_SCALE - {2'h0, st_next.ctl.drive_step};
    st_next.ctl.standby = st_next.ctl.power_save && st_next.ctl.osc_on;
    st_next.ctl.dynamic_en = st_next.ctl.display_on && !st_next.ctl.power_save;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.ctl.drive_ratio <= DRIVE_FULL_SCALE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign awready = !st_reg.aw_held;
  assign wready = !st_reg.w_held;
  assign bvalid = st_reg.bvalid;
  assign bresp = st_reg.bresp;
  assign arready = !st_reg.rvalid;
  assign rvalid = st_reg.rvalid;
  assign rdata = st_reg.rdata;
  assign rresp = st_reg.rresp;
  assign panel = st_reg.ctl;
  assign ram_wr = st_reg.ram;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_deselect_clears: assert property (pins.cs_n |=> st_reg.shift == 8'h00 && st_reg.cnt == 3'h0)
    else $error("shifter not cleared while deselected");
  a_deselect_ignores: assert property (pins.cs_n |-> !fire && !par_edge && !scl_rise)
    else $error("byte accepted while deselected");
  a_msb_first: assert property (scl_rise && st_reg.cnt != 3'h7 |=>
      st_reg.shift == {$past(st_reg.shift[6:0]), $past(pins.data[7])})
    else $error("serial bit not shifted in at the bottom");
  a_eighth_hands: assert property (scl_rise && st_reg.cnt == 3'h7 |-> fire && fire_a0 == pins.a0)
    else $error("eighth serial clock did not hand over the byte");
  a_count_wraps: assert property (scl_rise && st_reg.cnt == 3'h7 |=> st_reg.cnt == 3'h0)
    else $error("bit counter did not wrap");
  a_mode_source: assert property (fire |-> (pins.ps ? par_edge : scl_rise))
    else $error("byte came from the unselected port");
  a_nibble_pair: assert property (fire && pins.ps && !pins.width |->
      st_reg.phase == PH_LOW ##1 st_reg.phase == PH_HIGH)
    else $error("four-bit byte not made of two halves");
  a_data_write: assert property (fire && fire_a0 && !init_req |=>
      ram_wr.valid && ram_wr.data == $past(fire_byte) && ram_wr.addr == $past(st_reg.addr_cnt))
    else $error("display data not written to the address counter");
  a_command_only: assert property (fire && !fire_a0 |=> !ram_wr.valid)
    else $error("command byte leaked onto the RAM path");
  a_init_clears: assert property (init_req |=> !panel.display_on && !panel.power_on &&
      panel.drive_step == DRIVE_STEP_RESET && panel.icons == 20'h0)
    else $error("reset left control state set");
  a_drive_level: assert property (panel.drive_ratio + {2'h0, panel.drive_step} == DRIVE_FULL_SCALE)
    else $error("drive level does not follow the step");
  a_standby_static: assert property (panel.power_save |-> !panel.dynamic_en)
    else $error("dynamic display running in standby");
  a_resp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");

  c_serial_byte: cover property (scl_rise && st_reg.cnt == 3'h7);
  c_nibble_byte: cover property (fire && pins.ps && !pins.width);
  c_enable_write: cover property (fire && pins.ps && pins.family && pins.width);
  c_bus_read: cover property (rvalid && rready && rresp == RESP_OKAY);

endmodule

/* File: hdl/pin_sync.sv */
// Two-stage synchroniser for a bundle of asynchronous pins
`timescale 1ns/1ps

module pin_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] IDLE = '0
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pins in, sampled levels out
  input wire logic [W-1:0] pins_in,
  output logic [W-1:0] pins_out
);

  typedef struct packed {
    logic [W-1:0] first;
    logic [W-1:0] second;
  } sync_state_t;

  sync_state_t st_reg;
  sync_state_t st_next;

  ////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second stage, never any logic
  always_comb begin
    st_next.first = pins_in;
    st_next.second = st_reg.first;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= {IDLE, IDLE};
    end else begin
      st_reg <= st_next;
    end
  end

  assign pins_out = st_reg.second;

endmodule

/* File: tb/host_mpu_model.sv */
// Behavioural microprocessor that drives the controller's host pins
`timescale 1ns/1ps

module host_mpu_model (
  // Clock
  input wire logic aclk,
  // Host pins
  output logic ps,
  output logic family,
  output logic width,
  output logic cs_n,
  output logic a0,
  output logic strobe,
  output logic [7:0] dbus,
  output logic init_n
);
  logic lclk;

  ////////////////////////////////////////////////////////////////////////
  // Idle pins; link clock phase kept apart from aclk
  initial begin
    {ps, family, width, a0, dbus} = '0;
    {cs_n, strobe, init_n} = 3'b111;
    lclk = 1'b0;
    #1.7;
    forever #32 lclk = ~lclk;
  end

  // Mode pins change only while deselected
  task automatic set_mode(input logic p, input logic f, input logic w);
    @(posedge aclk);
    ps <= p;
    family <= p & f;
    width <= p & w;
    strobe <= ~(p & f);
    repeat (4) @(posedge aclk);
  endtask

  // One byte, split into nibbles on the upper lines when narrow
  task automatic par_write(input logic dc, input logic [7:0] b);
    logic [7:0] v [2];
    int n;
    n = width ? 1 : 2;
    v[0] = width ? b : {b[7:4], ~b[7:4]};
    v[1] = {b[3:0], ~b[3:0]};
    @(posedge aclk);
    cs_n <= 1'b0;
    a0 <= dc;
    for (int k = 0; k < n; k++) begin
      @(posedge aclk);
      dbus <= v[k];
      strobe <= family;
      repeat (4) @(posedge aclk);
      strobe <= ~family;
      repeat (4) @(posedge aclk);
      dbus <= ~v[k];
    end
    cs_n <= 1'b1;
    a0 <= ~dc;
    repeat (4) @(posedge aclk);
  endtask

  // Chip select level, held a few cycles so it is seen
  task automatic sel(input logic lvl);
    @(posedge aclk);
    cs_n <= lvl;
    repeat (4) @(posedge aclk);
  endtask

  // Serial bits MSB first; clock only runs inside the byte
  task automatic ser_byte(input logic dc, input logic [7:0] b, input int nb);
    for (int i = 7; i > 7 - nb; i--) begin
      @(negedge lclk);
      dbus <= {b[i], 1'b0, ~dbus[5:0]};
      a0 <= dc;
      @(posedge lclk);
      dbus[6] <= 1'b1;
    end
    @(negedge lclk);
    dbus <= {~dbus[7], 1'b0, ~dbus[5:0]};
  endtask

  // Device initialisation pulse
  task automatic init_pulse;
    @(posedge aclk);
    init_n <= 1'b0;
    repeat (4) @(posedge aclk);
    init_n <= 1'b1;
    repeat (4) @(posedge aclk);
  endtask
endmodule

/* File: tb/test_lcd_write_port.sv */
// Self-checking bench for the LCD controller host write port
`timescale 1ns/1ps

module test_lcd_write_port;
  import lcd_port_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic ps, family, width, cs_n, a0, strobe, init_n;
  logic [7:0] dbus;
  panel_ctrl_t panel, ep;
  ram_write_t ram_wr;
  logic [14:0] rq [$];
  int checks = 0;
  int mismatches = 0;

  ////////////////////////////////////////////////////////////////////////
  // 200 MHz clock
  always #2.5 aclk = ~aclk;

  lcd_write_port dut (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .parallel_serial_select(ps), .bus_family_select(family), .bus_width_select(width),
    .chip_select_n(cs_n), .data_command_select(a0), .write_strobe(strobe),
    .data_bus_in(dbus), .device_init_n(init_n),
    .panel(panel), .ram_wr(ram_wr)
  );

  host_mpu_model host (
    .aclk(aclk), .ps(ps), .family(family), .width(width), .cs_n(cs_n),
    .a0(a0), .strobe(strobe), .dbus(dbus), .init_n(init_n)
  );

  // Every one-cycle RAM write pulse is queued for later comparison
  always @(posedge aclk) begin
    if (ram_wr.valid === 1'b1) rq.push_back({ram_wr.addr, ram_wr.data});
  end

  ////////////////////////////////////////////////////////////////////////
  // Verdict and comparison
  task results;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Oldest queued RAM write against the expected address and byte
  task automatic cmp_ram(input logic [6:0] a, input logic [7:0] d);
    logic [14:0] g;
    g = 15'h7FFF;
    if (rq.size() > 0) g = rq.pop_front();
    cmp(64'(g), 64'({a, d}));
  endtask

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite master; waits for the answer, only the watchdog ends a wait
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    cmp(64'(bresp), 64'(er));
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    cmp(64'(rdata), 64'(ed));
    cmp(64'(rresp), 64'(er));
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Hang guard, well beyond the expected run
  initial begin
    #200000;
    mismatches++;
    results;
  end

  // Main sequence
  initial begin
    ep = '0;
    ep.drive_ratio = DRIVE_FULL_SCALE;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    cmp(64'(panel), 64'(ep));
    axi_read(8'h18, 32'h0, RESP_SLVERR);
    axi_write(8'h18, 32'h1, RESP_SLVERR);
    // Wide bus, write-strobe style; power on before the drive step
    host.set_mode(1'b1, 1'b0, 1'b1);
    host.par_write(1'b0, 8'h51);
    host.par_write(1'b0, 8'h85);
    host.par_write(1'b1, 8'hA5);
    cmp_ram(7'h05, 8'hA5);
    // Wide bus, enable style; address counter advances
    host.set_mode(1'b1, 1'b1, 1'b1);
    host.par_write(1'b1, 8'h3C);
    cmp_ram(7'h06, 8'h3C);
    // Narrow bus in both styles; top drive step code
    host.set_mode(1'b1, 1'b1, 1'b0);
    host.par_write(1'b0, 8'hA8);
    host.par_write(1'b1, 8'h1F);
    cmp_ram(ADDR_DRIVE_STEP, 8'h1F);
    host.set_mode(1'b1, 1'b0, 1'b0);
    host.par_write(1'b0, 8'h31);
    ep.power_on = 1'b1;
    ep.drive_step = 5'h1F;
    ep.drive_ratio = 7'h40;
    ep.display_on = 1'b1;
    ep.dynamic_en = 1'b1;
    cmp(64'(panel), 64'(ep));
    // Serial: broken byte dropped on deselect, then two bytes in one frame
    host.set_mode(1'b0, 1'b0, 1'b0);
    host.sel(1'b0);
    host.ser_byte(1'b1, 8'hFF, 3);
    host.sel(1'b1);
    host.sel(1'b0);
    host.ser_byte(1'b0, 8'h43, 8);
    host.ser_byte(1'b1, 8'h5A, 8);
    host.sel(1'b1);
    cmp_ram(7'h29, 8'h5A);
    ep.osc_on = 1'b1;
    ep.power_save = 1'b1;
    ep.standby = 1'b1;
    ep.dynamic_en = 1'b0;
    cmp(64'(panel), 64'(ep));
    axi_read(REG_STATUS, 32'h002A0018, RESP_OKAY);
    axi_write(REG_DISPLAY, 32'hFFFF, RESP_OKAY);
    axi_read(REG_DISPLAY, 32'h71, RESP_OKAY);
    axi_read(REG_LEVELS, 32'h81F, RESP_OKAY);
    axi_read(REG_BYTES, 32'h9, RESP_OKAY);
    // Soft init, then a rewritten command, then pin init while deselected
    axi_write(REG_CONTROL, 32'h1, RESP_OKAY);
    ep = '0;
    ep.drive_ratio = DRIVE_FULL_SCALE;
    cmp(64'(panel), 64'(ep));
    host.set_mode(1'b1, 1'b0, 1'b1);
    host.par_write(1'b0, 8'h31);
    cmp(64'(panel.display_on), 64'(1));
    // Icons, LED, system setup and cursor home through the write path
    host.par_write(1'b0, 8'hA0);
    host.par_write(1'b1, 8'h15);
    host.par_write(1'b1, 8'h0A);
    host.par_write(1'b0, 8'hAA);
    host.par_write(1'b1, 8'h13);
    host.par_write(1'b0, 8'h6F);
    host.par_write(1'b0, 8'h10);
    cmp_ram(7'h20, 8'h15);
    cmp_ram(7'h21, 8'h0A);
    cmp_ram(7'h2A, 8'h13);
    axi_read(REG_ICONS, 32'h155, RESP_OKAY);
    axi_read(REG_LEVELS, 32'h13BE0, RESP_OKAY);
    axi_read(REG_DISPLAY, 32'h781, RESP_OKAY);
    axi_read(REG_STATUS, 32'h0030002D, RESP_OKAY);
    host.init_pulse;
    cmp(64'(panel), 64'(ep));
    // Deselected serial traffic leaves no trace
    host.set_mode(1'b0, 1'b0, 1'b0);
    host.ser_byte(1'b1, 8'hFF, 8);
    host.ser_byte(1'b0, 8'h31, 8);
    repeat (8) @(posedge aclk);
    cmp(64'(rq.size()), 64'(0));
    cmp(64'(panel), 64'(ep));
    axi_read(REG_BYTES, 32'h11, RESP_OKAY);
    results;
  end
endmodule
